//--- logic/fe_mode_ctrl.sv
// Purpose: mode control, ability advertisement and status for two expansion ports
// Assumes: phy status inputs are synchronous to SYS_CLK_IN
// Notes:   desired mode takes effect on confirm; irq on link or mode change
`timescale 1ns/1ps
module fe_mode_ctrl
  import fe_mode_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
) (
  input  wire logic                  SYS_CLK_IN,
  input  wire logic                  NRST_IN,
  input  wire reg_req_t              REG_REQ_IN,
  output logic      [DATA_W-1:0]     REG_RDATA_OUT,
  input  wire phy_stat_t [PORTS-1:0] PHY_STAT_IN,
  output phy_ctrl_t [PORTS-1:0]      PHY_CTRL_OUT,
  output logic                       IRQ_OUT
);

  initial begin
    if (PORTS != NUM_PORTS) $error("only two expansion ports are served");
  end

  // best common mode of a mask, priority 100F, 100H, 10F, 10H
  function automatic logic [2:0] resolve(input logic [3:0] m);
    if (m[ABIL_100F])     resolve = MODE_100F;
    else if (m[ABIL_100H]) resolve = MODE_100H;
    else if (m[ABIL_10F])  resolve = MODE_10F;
    else if (m[ABIL_10H])  resolve = MODE_10H;
    else                   resolve = MODE_UNKN;
  endfunction : resolve

  function automatic logic is_fiber(input logic [1:0] t);
    is_fiber = (t == TYPE_FIBER_M) || (t == TYPE_FIBER_A);
  endfunction : is_fiber

  // next desired value on a step command for a given module type
  function automatic logic [2:0] step_mode(input logic [1:0] t, input logic [2:0] m);
    if (is_fiber(t))        step_mode = (m == MODE_100F) ? MODE_100H : MODE_100F;
    else if (m == MODE_100F) step_mode = MODE_AUTO;
    else                    step_mode = m + 3'h1;
  endfunction : step_mode

  // keep a written desired value legal for the fitted module type
  function automatic logic [2:0] legal_mode(input logic [1:0] t, input logic [2:0] m);
    if (is_fiber(t))        legal_mode = (m == MODE_100F) ? MODE_100F : MODE_100H;
    else if (m > MODE_100F) legal_mode = MODE_AUTO;
    else                    legal_mode = m;
  endfunction : legal_mode

  logic [PORTS-1:0][2:0] des_q, des_d;     // pending desired mode
  logic [PORTS-1:0][2:0] act_q, act_d;     // confirmed and held mode
  logic [PORTS-1:0][3:0] adv_q, adv_d;
  logic [PORTS-1:0][2:0] cur_q;
  logic [PORTS-1:0]      link_q;
  logic [PORTS-1:0][2:0] cur_w;
  logic [PORTS-1:0]      link_w;
  logic [IRQ_BITS-1:0]   irq_stat_q, irq_en_q, irq_set_w, irq_clr_w;
  logic [DATA_W-1:0]     rdata_q, rdata_w;

  // address split
  wire logic             in_port   = (REG_REQ_IN.addr < PORT_STRIDE * PORTS);
  wire logic             port_sel  = REG_REQ_IN.addr[4];
  wire logic [3:0]       reg_off   = REG_REQ_IN.addr[3:0];
  wire logic             wr_des    = REG_REQ_IN.wr && in_port && reg_off == REG_DESIRED;
  wire logic             wr_adv    = REG_REQ_IN.wr && in_port && reg_off == REG_ADV;
  wire logic             wr_cmd    = REG_REQ_IN.wr && in_port && reg_off == REG_CMD;
  wire logic             wr_iclr   = REG_REQ_IN.wr && REG_REQ_IN.addr == REG_IRQ_CLR;
  wire logic             wr_ien    = REG_REQ_IN.wr && REG_REQ_IN.addr == REG_IRQ_EN;

  // per-port mode resolution and config next values
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    wire logic [1:0] typ     = PHY_STAT_IN[p].mod_type;
    wire logic       fiber   = is_fiber(typ);
    wire logic       copper  = (typ == TYPE_COPPER);
    wire logic       sel     = (port_sel == 1'(p));
    wire logic       aneg    = copper && act_q[p] == MODE_AUTO;
    wire logic [2:0] neg     = resolve(adv_q[p] & PHY_STAT_IN[p].partner_abil);
    wire logic       no_com  = aneg && neg == MODE_UNKN;
    wire logic       fitted  = fiber || copper;

    assign link_w[p] = fitted && PHY_STAT_IN[p].link_sig && !no_com;
    // current mode: na when empty, resolved under auto, held setting otherwise
    assign cur_w[p]  = !fitted ? MODE_NA :
                       aneg ? (link_w[p] ? neg : MODE_UNKN) :
                       act_q[p];
    assign des_d[p]  = (sel && wr_cmd && REG_REQ_IN.wdata[CMD_STEP]) ?
                       step_mode(typ, des_q[p]) :
                       (sel && wr_des) ? legal_mode(typ, REG_REQ_IN.wdata[2:0]) :
                       legal_mode(typ, des_q[p]);
    assign act_d[p]  = (sel && wr_cmd && REG_REQ_IN.wdata[CMD_SAVE]) ? des_d[p] :
                       legal_mode(typ, act_q[p]);
    assign adv_d[p]  = (sel && wr_adv) ? REG_REQ_IN.wdata[3:0] : adv_q[p];

    // drive the phy: forced mode disables negotiation
    assign PHY_CTRL_OUT[p].aneg_en   = aneg;
    assign PHY_CTRL_OUT[p].adv       = aneg ? adv_q[p] : 4'h0;
    assign PHY_CTRL_OUT[p].link_en   = fitted && !no_com;
    assign PHY_CTRL_OUT[p].speed_100 = (cur_q[p] == MODE_100H) || (cur_q[p] == MODE_100F);
    assign PHY_CTRL_OUT[p].full_dup  = (cur_q[p] == MODE_100F) || (cur_q[p] == MODE_10F);

    assign irq_set_w[2*p]   = link_w[p] != link_q[p];
    assign irq_set_w[2*p+1] = cur_w[p] != cur_q[p];
  end

  assign irq_clr_w = wr_iclr ? REG_REQ_IN.wdata[IRQ_BITS-1:0] : '0;

  // read mux
  wire logic       rp = port_sel;
  assign rdata_w = !REG_REQ_IN.rd ? '0 :
    (in_port && reg_off == REG_STATUS) ?
      DATA_W'({des_q[rp], 1'b0, cur_q[rp], 1'b0, link_q[rp], PHY_STAT_IN[rp].mod_type}) :
    (in_port && reg_off == REG_DESIRED) ? DATA_W'(des_q[rp]) :
    (in_port && reg_off == REG_ADV)     ? DATA_W'(adv_q[rp]) :
    (REG_REQ_IN.addr == REG_IRQ_STAT)   ? DATA_W'(irq_stat_q) :
    (REG_REQ_IN.addr == REG_IRQ_EN)     ? DATA_W'(irq_en_q) : '0;

  // config registers; reset to auto with all abilities advertised
  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      des_q <= '0;
      act_q <= '0;
      adv_q <= {PORTS{ABIL_RESET}};
    end else begin
      des_q <= des_d;
      act_q <= act_d;
      adv_q <= adv_d;
    end
  end

  // status, interrupt and read data registers; set wins over clear
  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      cur_q      <= {PORTS{MODE_NA}};
      link_q     <= '0;
      irq_stat_q <= '0;
      irq_en_q   <= '0;
      rdata_q    <= '0;
    end else begin
      cur_q      <= cur_w;
      link_q     <= link_w;
      irq_stat_q <= (irq_stat_q & ~irq_clr_w) | irq_set_w;
      irq_en_q   <= wr_ien ? REG_REQ_IN.wdata[IRQ_BITS-1:0] : irq_en_q;
      rdata_q    <= rdata_w;
    end
  end

  assign REG_RDATA_OUT = rdata_q;
  assign IRQ_OUT       = |(irq_stat_q & irq_en_q);

  // checks
  AST_FORCED_NO_ANEG: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    PHY_STAT_IN[0].mod_type == TYPE_COPPER && act_q[0] != MODE_AUTO
      |-> !PHY_CTRL_OUT[0].aneg_en) else $error("forced mode left negotiation on");
  AST_FIBER_DES: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    is_fiber(PHY_STAT_IN[0].mod_type) && $stable(PHY_STAT_IN[0].mod_type)
      |-> des_q[0] == MODE_100H || des_q[0] == MODE_100F) else $error("bad fiber mode");
  AST_EMPTY_NA: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    PHY_STAT_IN[0].mod_type == TYPE_UNKNOWN |=> cur_q[0] == MODE_NA || !$stable(PHY_STAT_IN[0].mod_type))
    else $error("empty slot not na");
  AST_NOLINK: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    !PHY_STAT_IN[0].link_sig |=> !link_q[0]) else $error("link without signal");
  AST_NOCOMMON: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    g_port[0].no_com |=> !link_q[0]) else $error("link without common mode");
  AST_RESOLVE: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    g_port[0].aneg && link_w[0] && adv_q[0][ABIL_100F] && PHY_STAT_IN[0].partner_abil[ABIL_100F]
      |=> cur_q[0] == MODE_100F) else $error("not best mode");
  AST_SAVE_HELD: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    wr_cmd && !port_sel && REG_REQ_IN.wdata[CMD_SAVE] && !REG_REQ_IN.wdata[CMD_STEP]
      && $stable(PHY_STAT_IN[0].mod_type) |=> act_q[0] == $past(des_q[0]))
    else $error("save not applied");
  AST_ADV_MASK: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    (PHY_CTRL_OUT[0].adv & ~adv_q[0]) == 4'h0) else $error("disabled ability advertised");
  AST_IRQ: assert property (@(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    irq_set_w[0] |=> irq_stat_q[0]) else $error("event lost");

  COV_FORCE: cover property (@(posedge SYS_CLK_IN) wr_cmd && REG_REQ_IN.wdata[CMD_SAVE]);
  COV_AUTO100: cover property (@(posedge SYS_CLK_IN) cur_q[0] == MODE_100F && link_q[0]);
  COV_FIBER: cover property (@(posedge SYS_CLK_IN) is_fiber(PHY_STAT_IN[1].mod_type) && link_q[1]);
  COV_IRQ: cover property (@(posedge SYS_CLK_IN) IRQ_OUT);

endmodule : fe_mode_ctrl

//--- logic/fe_mode_pkg.sv
// Purpose: constants and types for the fast-ethernet expansion port mode control
// Assumes: two expansion ports, numbered five and six, each on its own register block
// Notes:   register map, field codes, reset values
package fe_mode_pkg;

  localparam int NUM_PORTS      = 2;
  localparam int FIRST_PORT_NUM = 5;
  localparam int ADDR_W         = 8;
  localparam int DATA_W         = 32;

  // module type codes
  localparam logic [1:0] TYPE_UNKNOWN = 2'h0;
  localparam logic [1:0] TYPE_COPPER  = 2'h1;
  localparam logic [1:0] TYPE_FIBER_M = 2'h2;
  localparam logic [1:0] TYPE_FIBER_A = 2'h3;

  // current/desired mode codes
  localparam logic [2:0] MODE_AUTO  = 3'h0; // desired only; current reads unknown
  localparam logic [2:0] MODE_10H   = 3'h1;
  localparam logic [2:0] MODE_10F   = 3'h2;
  localparam logic [2:0] MODE_100H  = 3'h3;
  localparam logic [2:0] MODE_100F  = 3'h4;
  localparam logic [2:0] MODE_NA    = 3'h7;
  localparam logic [2:0] MODE_UNKN  = 3'h0;

  // ability mask bits
  localparam int ABIL_10H  = 0;
  localparam int ABIL_10F  = 1;
  localparam int ABIL_100H = 2;
  localparam int ABIL_100F = 3;
  localparam logic [3:0] ABIL_RESET = 4'hF;

  // per-port register block: port p at base p*PORT_STRIDE
  localparam logic [ADDR_W-1:0] PORT_STRIDE = 8'h10;
  localparam logic [3:0] REG_STATUS  = 4'h0; // ro: type[1:0] link[2] cur[6:4] des[10:8]
  localparam logic [3:0] REG_DESIRED = 4'h4; // rw: mode[2:0]
  localparam logic [3:0] REG_ADV     = 4'h8; // rw: ability mask[3:0]
  localparam logic [3:0] REG_CMD     = 4'hC; // wo: bit0 step desired mode, bit1 confirm
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h80; // ro
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR  = 8'h84; // wo, write one to clear
  localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 8'h88; // rw
  localparam int STAT_LINK_LSB = 2;
  localparam int STAT_CUR_LSB  = 4;
  localparam int STAT_DES_LSB  = 8;
  localparam int CMD_STEP      = 0;
  localparam int CMD_SAVE      = 1;
  localparam int IRQ_BITS      = 2 * NUM_PORTS; // per port: link change, mode change

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] mod_type;
    logic       link_sig;
    logic [3:0] partner_abil;
  } phy_stat_t;

  typedef struct packed {
    logic       link_en;
    logic       speed_100;
    logic       full_dup;
    logic       aneg_en;
    logic [3:0] adv;
  } phy_ctrl_t;

endpackage : fe_mode_pkg

//--- bench/far_end_phy.sv
// Purpose: far-end link partner model for both expansion ports
// Assumes: bench picks module type, cable state and partner abilities
// Notes:   an empty slot shows a changing pattern on its ability lines
`timescale 1ns/1ps
module far_end_phy
  import fe_mode_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic [3:0]      type_in,
  input  wire logic [1:0]      cable_in,
  input  wire logic [7:0]      abil_in,
  output phy_stat_t [1:0]      stat_out
);
  logic [3:0] noise_q = 4'h5;
  // lines of an empty slot are not driven, so they wander
  always_ff @(posedge clk_in) begin
    noise_q <= ~noise_q + 4'h3;
  end
  // link only with a module fitted and the cable good
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      stat_out[p].mod_type     = type_in[2*p +: 2];
      stat_out[p].link_sig     = (type_in[2*p +: 2] != TYPE_UNKNOWN) && cable_in[p];
      stat_out[p].partner_abil = (type_in[2*p +: 2] != TYPE_UNKNOWN) ? abil_in[4*p +: 4]
                                                                    : noise_q;
    end
  end
endmodule : far_end_phy

//--- bench/tb_top.sv
// Purpose: self-checking bench for the expansion port mode control
// Assumes: one clock, synchronous active-low reset
// Notes:   expected values come from a small integer model of the port
`timescale 1ns/1ps
module tb_top;
  import fe_mode_pkg::*;
  logic clk, nrst, irq;
  reg_req_t req;
  logic [DATA_W-1:0] rdata, d;
  phy_stat_t [1:0] stat;
  phy_ctrl_t [1:0] ctrl;
  logic [3:0] ptype;
  logic [1:0] cable;
  logic [7:0] pabil;
  logic [31:0] seed = 32'h7453;
  int errors, n_tests, e, prev;
  logic [3:0] m;

  fe_mode_ctrl #(.PORTS(2)) fe_mode_ctrl_inst (.SYS_CLK_IN(clk), .NRST_IN(nrst),
    .REG_REQ_IN(req), .REG_RDATA_OUT(rdata), .PHY_STAT_IN(stat), .PHY_CTRL_OUT(ctrl),
    .IRQ_OUT(irq));
  far_end_phy far_end_phy_inst (.clk_in(clk), .type_in(ptype), .cable_in(cable),
    .abil_in(pabil), .stat_out(stat));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // best common mode: highest set ability bit plus one, 0 when none
  function automatic int best(logic [3:0] a);
    for (int i = 3; i >= 0; i--) if (a[i]) return i + 1;
    return 0;
  endfunction : best
  function automatic logic [31:0] sw(int t, int l, int c, int ds);
    return 32'(t | (l << 2) | (c << 4) | (ds << 8));
  endfunction : sw
  function automatic logic [31:0] cw(logic le, int md, logic an, logic [3:0] a);
    return {24'h0, le, md >= 3, md == 2 || md == 4, an, a};
  endfunction : cw
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic phy(input logic [3:0] t, input logic [1:0] c, input logic [7:0] a);
    @(posedge clk);
    ptype <= t;
    cable <= c;
    pabil <= a;
    repeat (3) @(posedge clk);
    #1;
  endtask : phy
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    req = '0;
    nrst = 1'b0;
    ptype = 4'h0;
    cable = 2'h0;
    pabil = 8'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h00); chk(d, sw(0, 0, 7, 0));
    rd(8'h10); chk(d, sw(0, 0, 7, 0));
    rd(8'h08); chk(d, 32'hF);
    rd(8'h40); chk(d, 32'h0);
    $display("test reset done");
    // interrupt: raise, mask, clear
    wr(REG_IRQ_EN, 32'h1);
    phy(4'h1, 2'h1, 8'h0F);
    rd(8'h00); chk(d, sw(1, 1, 4, 0));
    chk(32'(irq), 32'h1);
    wr(REG_IRQ_EN, 32'h0); #1 chk(32'(irq), 32'h0);
    wr(REG_IRQ_CLR, 32'hF);
    wr(REG_IRQ_EN, 32'h1);
    rd(REG_IRQ_STAT); chk(d, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test irq done");
    // negotiation over random masks and partners
    for (int i = 0; i < 16; i++) begin
      m = 4'(rnd());
      wr(8'h08, {28'h0, m});
      phy(4'h1, 2'h1, {4'h0, 4'(rnd())});
      e = best(m & pabil[3:0]);
      rd(8'h00); chk(d, sw(1, e != 0, e, 0));
      chk(32'(ctrl[0]) & (e != 0 ? 32'hFF : 32'h9F), cw(e != 0, e, 1, m));
    end
    $display("test negotiate done");
    // forced copper modes, effective only on save
    wr(8'h08, 32'hF);
    phy(4'h1, 2'h1, 8'h0F);
    prev = 4;
    for (int f = 1; f <= 4; f++) begin
      wr(8'h04, f);
      rd(8'h00); chk(d, sw(1, 1, prev, f));
      wr(8'h0C, 32'h2);
      rd(8'h00); chk(d, sw(1, 1, f, f));
      chk(32'(ctrl[0]), cw(1, f, 0, 4'h0));
      prev = f;
    end
    for (int i = 1; i <= 5; i++) begin
      wr(8'h0C, 32'h1);
      rd(8'h00); chk((d >> 8) & 32'h7, (4 + i) % 5);
    end
    $display("test copper done");
    // fiber on port six, desired mode forced to 100H then stepped and saved between 100H and 100F
    for (int t = 2; t <= 3; t++) begin
      phy({2'(t), 2'h1}, 2'h3, 8'h0F);
      wr(8'h14, 32'h1);
      rd(8'h10); chk((d >> 8) & 32'h7, 32'h3);
      wr(8'h1C, 32'h1);
      rd(8'h10); chk((d >> 8) & 32'h7, 32'h4);
      wr(8'h1C, 32'h1);
      rd(8'h10); chk((d >> 8) & 32'h7, 32'h3);
      wr(8'h1C, 32'h3);
      rd(8'h10); chk(d, sw(t, 1, 4, 4));
      chk(32'(ctrl[1]) & 32'hF0, cw(1, 4, 0, 4'h0));
      wr(8'h1C, 32'h3);
      rd(8'h10); chk(d, sw(t, 1, 3, 3));
    end
    $display("test fiber done");
    end_of_test();
  end
endmodule : tb_top
